// file: smcr_map.vh
`ifndef SMCR_MAP_VH
`define SMCR_MAP_VH

// Register word indices, byte address is index times four
`define SMCR_IDX_PROT 6'h00
`define SMCR_IDX_PWRCTL 6'h01
`define SMCR_IDX_STOPCTL 6'h02
`define SMCR_IDX_STATUS 6'h03

// Mode protection fields
`define SMCR_AVLP_BIT 5
`define SMCR_ALLS_BIT 3
`define SMCR_AVLLS_BIT 1

// Power mode control fields
`define SMCR_ABORT_BIT 3
`define SMCR_SEL_MSB 2

// Stop control fields
`define SMCR_PART_MSB 7
`define SMCR_PART_LSB 6
`define SMCR_PORDET_BIT 5
`define SMCR_SUB_MSB 2

// Status fields
`define SMCR_STAT_MODE_LSB 4
`define SMCR_STAT_MODE_MSB 7

// Reset values
`define SMCR_REG_RST 8'h00
`define SMCR_WORD_RST 32'h0000_0000
`define SMCR_PAD_ZERO 24'h00_0000

// Stop mode selector codes
`define SMCR_SEL_NORMAL 3'h0
`define SMCR_SEL_VLP 3'h2
`define SMCR_SEL_LEAK 3'h3
`define SMCR_SEL_VLEAK 3'h4

// Partial stop option codes
`define SMCR_PSTOP_NONE 2'h0
`define SMCR_PSTOP_BUS_GATED 2'h1
`define SMCR_PSTOP_BUS_RUN 2'h2

// Leakage sub-mode codes
`define SMCR_SUB_ZERO 3'h0
`define SMCR_SUB_ONE 3'h1
`define SMCR_SUB_THREE 3'h3

// Effective stop mode codes
`define SMCR_MODE_STOP 4'h0
`define SMCR_MODE_PSTOP_GATED 4'h1
`define SMCR_MODE_PSTOP_RUN 4'h2
`define SMCR_MODE_VLP_STOP 4'h3
`define SMCR_MODE_LEAK 4'h4
`define SMCR_MODE_SUB0 4'h5
`define SMCR_MODE_SUB1 4'h6
`define SMCR_MODE_SUB3 4'h7

`endif

// file: smcr_ahb.v
`timescale 1ns/1ns
`default_nettype none
`include "smcr_map.vh"

module smcr_ahb (
  input wire i_ref_clk, // Bus clock
  input wire i_arst_n, // Power-on reset, active low
  input wire i_clk_en, // Freezes state while low
  input wire i_hsel, // Slave select
  input wire [31:0] i_haddr, // Byte address
  input wire [1:0] i_htrans, // Transfer type
  input wire i_hwrite, // Write when high
  input wire [31:0] i_hwdata, // Write data
  input wire i_hready, // Bus ready
  input wire [7:0] i_rdata, // Register read value for o_idx
  output reg [31:0] o_hrdata, // Read data
  output reg o_hreadyout, // Slave ready
  output reg o_hresp, // Always OKAY
  output reg [5:0] o_idx, // Latched word index
  output wire o_wr_stb, // Write strobe, one cycle
  output wire [7:0] o_wdata // Write data low byte
);

  reg pend;
  reg pend_wr;

  // One wait state so a read always sees the write before it
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend <= 1'b0;
      pend_wr <= 1'b0;
      o_idx <= 6'h00;
      o_hrdata <= `SMCR_WORD_RST;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else if (i_clk_en) begin
      if (pend) begin
        pend <= 1'b0;
        o_hreadyout <= 1'b1;
        if (!pend_wr) begin
          o_hrdata <= {`SMCR_PAD_ZERO, i_rdata};
        end
      end else if (i_hsel && i_htrans[1] && i_hready) begin
        pend <= 1'b1;
        pend_wr <= i_hwrite;
        o_idx <= i_haddr[7:2];
        o_hreadyout <= 1'b0;
      end
    end
  end

  assign o_wr_stb = pend & pend_wr & i_clk_en;
  assign o_wdata = i_hwdata[7:0];

endmodule // smcr_ahb
`default_nettype wire

// file: smcr_mode_dec.v
`timescale 1ns/1ns
`default_nettype none
`include "smcr_map.vh"

module smcr_mode_dec (
  input wire [2:0] i_stop_mode_select, // Selector
  input wire [1:0] i_partial_stop_option, // Partial stop choice
  input wire [2:0] i_leakage_submode_select, // Leakage sub-mode
  input wire i_power_on_detect_option, // 1 disables detect in sub-mode zero
  output reg [3:0] o_mode, // Effective stop mode
  output reg o_gate_bus, // Bus clock gated
  output reg o_keep_powered, // Supplies and flash stay on
  output reg o_por_off // Power-on detect disabled
);

  always @* begin
    o_mode = `SMCR_MODE_STOP;
    case (i_stop_mode_select)
      `SMCR_SEL_NORMAL: begin
        case (i_partial_stop_option)
          `SMCR_PSTOP_BUS_GATED: o_mode = `SMCR_MODE_PSTOP_GATED;
          `SMCR_PSTOP_BUS_RUN: o_mode = `SMCR_MODE_PSTOP_RUN;
          default: o_mode = `SMCR_MODE_STOP;
        endcase
      end
      `SMCR_SEL_VLP: o_mode = `SMCR_MODE_VLP_STOP;
      `SMCR_SEL_LEAK: o_mode = `SMCR_MODE_LEAK;
      `SMCR_SEL_VLEAK: begin
        case (i_leakage_submode_select)
          `SMCR_SUB_ZERO: o_mode = `SMCR_MODE_SUB0;
          `SMCR_SUB_ONE: o_mode = `SMCR_MODE_SUB1;
          `SMCR_SUB_THREE: o_mode = `SMCR_MODE_SUB3;
          default: o_mode = `SMCR_MODE_SUB3;
        endcase
      end
      default: o_mode = `SMCR_MODE_STOP;
    endcase
    o_gate_bus = (o_mode != `SMCR_MODE_PSTOP_RUN);
    o_keep_powered = (o_mode == `SMCR_MODE_PSTOP_GATED) || (o_mode == `SMCR_MODE_PSTOP_RUN);
    o_por_off = (o_mode == `SMCR_MODE_SUB0) && i_power_on_detect_option;
  end

endmodule // smcr_mode_dec
`default_nettype wire

// file: smcr_top.v
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "smcr_map.vh"

// Operation
// (RL1) Three-bit selector: four stop kinds
// (RL2) Deep sleep entry enters the selected mode
// (RL3) Selector writes need matching allow bit
// (RL4) Protection write clears the selector
// (RL5) Leakage mode uses sub-mode field; the code reads it only for SMCR_SEL_VLEAK, not for SMCR_SEL_LEAK
// (RL6) Normal stop consults partial stop option
// (RL7) Option codes: normal, bus gated, bus running
// (RL8) Bus-running variant gates system clocks only
// (RL9) Bus-gated variant gates system and bus
// (RL10) Partial stop keeps supplies and flash powered
// (RL11) Bit five disables power-on detect
// (RL12) Sub-mode codes zero, one, three
// (RL13) Stop control bits four, three read zero
// (RL14) Stop control reset only by power-on
// (RL15) Stop control at index two
// (RL16) Allow bits are write-once after reset
// (RL17) Abort flag cleared at entry, set on abort
// (RL18) Software avoids reserved codes
module smcr_top (
  input wire i_ref_clk, // Bus clock, 50 MHz
  input wire i_arst_n, // Chip power-on reset, active low
  input wire i_clk_en, // Freezes all state while low
  input wire i_sys_rst_n, // Other system resets, synchronous, active low
  input wire i_sleep_req, // Core entered sleep-now or sleep-on-exit
  input wire i_deep_sleep_flag, // Core deep sleep flag
  input wire i_wake_req, // Interrupt pending, wakes or aborts
  input wire i_hsel, // AHB slave select
  input wire [31:0] i_haddr, // AHB address
  input wire [1:0] i_htrans, // AHB transfer type
  input wire i_hwrite, // AHB write
  input wire [31:0] i_hwdata, // AHB write data
  input wire i_hready, // AHB ready
  output wire [31:0] o_hrdata, // AHB read data
  output wire o_hreadyout, // AHB slave ready
  output wire o_hresp, // AHB response
  output reg o_gate_sys_clk, // System clocks gated
  output reg o_gate_bus_clk, // Bus clock gated
  output reg o_keep_powered, // Supplies, clock unit, flash stay on
  output reg o_por_detect_off, // Power-on detect disabled
  output reg [3:0] o_stop_mode, // Mode entered
  output reg o_in_stop // Stop mode active
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_ENTRY = 2'b01;
  localparam [1:0] ST_STOP = 2'b10;

  reg [7:0] mode_protection_reg;
  reg prot_locked;
  reg [2:0] stop_mode_select;
  reg stop_abort_flag;
  reg [1:0] partial_stop_option;
  reg power_on_detect_option;
  reg [2:0] leakage_submode_select;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [7:0] rd_data;

  wire [5:0] bus_idx;
  wire wr_stb;
  wire [7:0] wr_data;
  wire [3:0] dec_mode;
  wire dec_gate_bus;
  wire dec_keep_powered;
  wire dec_por_off;
  wire sleep_entry;
  wire wr_prot;
  wire wr_pwrctl;
  wire wr_stopctl;

  // Reserved or unpermitted codes are refused
  function mode_allowed;
    input [2:0] code;
    input [7:0] prot;
    begin
      case (code)
        `SMCR_SEL_NORMAL: mode_allowed = 1'b1;
        `SMCR_SEL_VLP: mode_allowed = prot[`SMCR_AVLP_BIT];
        `SMCR_SEL_LEAK: mode_allowed = prot[`SMCR_ALLS_BIT];
        `SMCR_SEL_VLEAK: mode_allowed = prot[`SMCR_AVLLS_BIT];
        default: mode_allowed = 1'b0;
      endcase
    end
  endfunction

  function reg_hit;
    input [5:0] idx;
    input [5:0] want;
    begin
      reg_hit = (idx == want);
    end
  endfunction

  smcr_ahb u_ahb (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_clk_en(i_clk_en),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hwdata(i_hwdata),
    .i_hready(i_hready),
    .i_rdata(rd_data),
    .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_idx(bus_idx),
    .o_wr_stb(wr_stb),
    .o_wdata(wr_data)
  );

  smcr_mode_dec u_dec (
    .i_stop_mode_select(stop_mode_select), // see (RL1)
    .i_partial_stop_option(partial_stop_option), // see (RL6)
    .i_leakage_submode_select(leakage_submode_select), // see (RL5)
    .i_power_on_detect_option(power_on_detect_option), // see (RL11)
    .o_mode(dec_mode),
    .o_gate_bus(dec_gate_bus),
    .o_keep_powered(dec_keep_powered),
    .o_por_off(dec_por_off)
  );

  assign wr_prot = wr_stb && reg_hit(bus_idx, `SMCR_IDX_PROT);
  assign wr_pwrctl = wr_stb && reg_hit(bus_idx, `SMCR_IDX_PWRCTL);
  assign wr_stopctl = wr_stb && reg_hit(bus_idx, `SMCR_IDX_STOPCTL); // see (RL15)
  assign sleep_entry = i_sleep_req && i_deep_sleep_flag; // see (RL2)

  // Read mux, unmapped words read zero
  always @* begin
    rd_data = `SMCR_REG_RST;
    case (bus_idx)
      `SMCR_IDX_PROT: rd_data = mode_protection_reg;
      `SMCR_IDX_PWRCTL: begin
        rd_data[`SMCR_ABORT_BIT] = stop_abort_flag;
        rd_data[`SMCR_SEL_MSB:0] = stop_mode_select;
      end
      `SMCR_IDX_STOPCTL: begin
        rd_data[`SMCR_PART_MSB:`SMCR_PART_LSB] = partial_stop_option; // see (RL7)
        rd_data[`SMCR_PORDET_BIT] = power_on_detect_option;
        rd_data[`SMCR_SUB_MSB:0] = leakage_submode_select; // see (RL13)
      end
      `SMCR_IDX_STATUS: begin
        rd_data[`SMCR_STAT_MODE_MSB:`SMCR_STAT_MODE_LSB] = o_stop_mode;
        rd_data[1:0] = state;
      end
      default: rd_data = `SMCR_REG_RST;
    endcase
  end

  // Protection cleared by every reset, write-once until then
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_protection_reg <= `SMCR_REG_RST;
      prot_locked <= 1'b0;
    end else if (i_clk_en) begin
      if (!i_sys_rst_n) begin
        mode_protection_reg <= `SMCR_REG_RST;
        prot_locked <= 1'b0;
      end else if (wr_prot && !prot_locked) begin // see (RL16)
        mode_protection_reg <= `SMCR_REG_RST;
        mode_protection_reg[`SMCR_AVLP_BIT] <= wr_data[`SMCR_AVLP_BIT];
        mode_protection_reg[`SMCR_ALLS_BIT] <= wr_data[`SMCR_ALLS_BIT];
        mode_protection_reg[`SMCR_AVLLS_BIT] <= wr_data[`SMCR_AVLLS_BIT];
        prot_locked <= 1'b1;
      end
    end
  end

  // Selector survives system resets, power-on only
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stop_mode_select <= `SMCR_SEL_NORMAL;
    end else if (i_clk_en) begin
      if (wr_prot && !prot_locked && i_sys_rst_n) begin
        stop_mode_select <= `SMCR_SEL_NORMAL; // see (RL4)
      end else if (wr_pwrctl && mode_allowed(wr_data[`SMCR_SEL_MSB:0], mode_protection_reg)) begin
        stop_mode_select <= wr_data[`SMCR_SEL_MSB:0]; // see (RL3)
      end
    end
  end

  // Only power-on clears stop control
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin // see (RL14)
      partial_stop_option <= `SMCR_PSTOP_NONE;
      power_on_detect_option <= 1'b0;
      leakage_submode_select <= `SMCR_SUB_ZERO;
    end else if (i_clk_en && wr_stopctl) begin
      partial_stop_option <= wr_data[`SMCR_PART_MSB:`SMCR_PART_LSB]; // see (RL7)
      power_on_detect_option <= wr_data[`SMCR_PORDET_BIT]; // see (RL11)
      leakage_submode_select <= wr_data[`SMCR_SUB_MSB:0]; // see (RL12)
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (sleep_entry) begin
          next_state = ST_ENTRY;
        end
      end
      ST_ENTRY: begin
        if (i_wake_req) begin
          next_state = ST_IDLE;
        end else begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (i_wake_req) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (!i_sys_rst_n) begin
      next_state = ST_IDLE;
    end
  end

  // Entry sequencer; mode is latched at the sleep request
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= ST_IDLE;
      stop_abort_flag <= 1'b0;
    end else if (i_clk_en) begin
      state <= next_state;
      if (state == ST_IDLE && sleep_entry && i_sys_rst_n) begin
        stop_abort_flag <= 1'b0; // see (RL17)
      end else if (state == ST_ENTRY && (i_wake_req || !i_sys_rst_n)) begin
        stop_abort_flag <= 1'b1; // see (RL17)
      end
    end
  end

  // Outputs other than o_stop_mode held for the whole stop, dropped on wake
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_gate_sys_clk <= 1'b0;
      o_gate_bus_clk <= 1'b0;
      o_keep_powered <= 1'b0;
      o_por_detect_off <= 1'b0;
      o_stop_mode <= `SMCR_MODE_STOP;
      o_in_stop <= 1'b0;
    end else if (i_clk_en) begin
      if (state == ST_IDLE && sleep_entry && i_sys_rst_n) begin
        o_stop_mode <= dec_mode; // see (RL2)
      end
      if (state == ST_ENTRY && next_state == ST_STOP) begin
        o_in_stop <= 1'b1;
        o_gate_sys_clk <= 1'b1; // see (RL8)
        o_gate_bus_clk <= dec_gate_bus; // see (RL9)
        o_keep_powered <= dec_keep_powered; // see (RL10)
        o_por_detect_off <= dec_por_off; // see (RL11)
      end else if (next_state != ST_STOP) begin
        o_in_stop <= 1'b0;
        o_gate_sys_clk <= 1'b0;
        o_gate_bus_clk <= 1'b0;
        o_keep_powered <= 1'b0;
        o_por_detect_off <= 1'b0;
      end
    end
  end

endmodule // smcr_top
`default_nettype wire

// file: smcr_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "smcr_map.vh"
module smcr_top_asserts (
  input wire logic i_ref_clk, // Bus clock
  input wire logic i_arst_n, // Power-on reset
  input wire logic i_clk_en, // Clock enable
  input wire logic i_sleep_req, // Sleep entered
  input wire logic i_deep_sleep_flag, // Deep flag
  input wire logic i_wake_req, // Interrupt pending
  input wire logic i_hsel, // Select
  input wire logic [31:0] i_haddr, // Address
  input wire logic [1:0] i_htrans, // Transfer type
  input wire logic i_hwrite, // Write
  input wire logic i_hready, // Bus ready
  input wire logic [31:0] o_hrdata, // Read data
  input wire logic o_hreadyout, // Slave ready
  input wire logic o_gate_sys_clk, // System gate
  input wire logic o_gate_bus_clk, // Bus gate
  input wire logic o_keep_powered, // Supplies on
  input wire logic o_por_detect_off, // Detect off
  input wire logic [3:0] o_stop_mode, // Mode entered
  input wire logic o_in_stop // In stop
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic taken = i_hsel && i_htrans[1] && i_hready && o_hreadyout && i_clk_en;
  a_bus_wait_state: assert property (
    taken |=> !o_hreadyout ##1 o_hreadyout) else $error("bus wait state wrong");
  a_ctrl_rsvd_zero: assert property (
    taken && !i_hwrite && i_haddr[7:2] == `SMCR_IDX_STOPCTL |=> ##1 o_hrdata[4:3] == 2'b00)
    else $error("reserved stop control bits set");
  a_entry_cause: assert property (
    $rose(o_in_stop) |-> $past(i_sleep_req && i_deep_sleep_flag, 2)) else $error("stop without request");
  a_wake_exit: assert property (
    o_in_stop && i_wake_req |=> !o_in_stop && !o_gate_sys_clk && !o_gate_bus_clk)
    else $error("wake did not end stop");
  a_sys_gate: assert property (
    o_gate_sys_clk == o_in_stop) else $error("system gate wrong");
  a_bus_gate: assert property (
    o_in_stop |-> o_gate_bus_clk == (o_stop_mode != `SMCR_MODE_PSTOP_RUN)) else $error("bus gate wrong");
  a_keep_power: assert property (
    o_in_stop |-> o_keep_powered == (o_stop_mode inside {`SMCR_MODE_PSTOP_GATED, `SMCR_MODE_PSTOP_RUN}))
    else $error("keep powered wrong");
  a_por_off_mode: assert property (
    o_por_detect_off |-> o_in_stop && o_stop_mode == `SMCR_MODE_SUB0) else $error("detect off wrongly");
  a_mode_hold: assert property (
    o_in_stop && $past(o_in_stop) |-> $stable(o_stop_mode)) else $error("mode changed in stop");
endmodule // smcr_top_asserts
bind smcr_top smcr_top_asserts u_chk (.i_ref_clk, .i_arst_n, .i_clk_en, .i_sleep_req, .i_deep_sleep_flag,
  .i_wake_req, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hready, .o_hrdata, .o_hreadyout, .o_gate_sys_clk,
  .o_gate_bus_clk, .o_keep_powered, .o_por_detect_off, .o_stop_mode, .o_in_stop);
`default_nettype wire

// file: smcr_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module smcr_core_model (
  input wire logic i_ref_clk, // Core clock
  output logic o_sleep_req, // Sleep entered
  output logic o_deep_sleep_flag, // Deep sleep flag
  output logic o_wake_req // Pending interrupt
);
  initial begin
    o_sleep_req = 1'b0;
    o_deep_sleep_flag = 1'b0;
    o_wake_req = 1'b0;
  end
  // Abort raises the interrupt while the entry is in flight
  task automatic sleep_now(input logic deep, input logic abort);
    o_sleep_req <= 1'b1;
    o_deep_sleep_flag <= deep;
    @(posedge i_ref_clk);
    o_sleep_req <= 1'b0;
    o_wake_req <= abort;
    @(posedge i_ref_clk);
    o_wake_req <= 1'b0;
    o_deep_sleep_flag <= 1'b0;
  endtask
  task automatic wake_up();
    o_wake_req <= 1'b1;
    @(posedge i_ref_clk);
    o_wake_req <= 1'b0;
  endtask
endmodule // smcr_core_model
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "smcr_map.vh"
module tb;
  logic i_ref_clk, i_arst_n, i_sys_rst_n, i_hsel, i_hwrite, o_hreadyout, o_hresp, o_in_stop;
  logic i_sleep_req, i_deep_sleep_flag, i_wake_req;
  logic o_gate_sys_clk, o_gate_bus_clk, o_keep_powered, o_por_detect_off;
  logic [31:0] i_haddr, i_hwdata, o_hrdata;
  logic [1:0] i_htrans;
  logic [3:0] o_stop_mode;
  int num_errors = 0;
  int n_checks = 0;
  localparam logic [31:0] A_PROT = {24'h00_0000, `SMCR_IDX_PROT, 2'b00};
  localparam logic [31:0] A_PM = {24'h00_0000, `SMCR_IDX_PWRCTL, 2'b00};
  localparam logic [31:0] A_SC = {24'h00_0000, `SMCR_IDX_STOPCTL, 2'b00};
  smcr_top u_dut (.i_ref_clk, .i_arst_n, .i_clk_en(1'b1), .i_sys_rst_n, .i_sleep_req, .i_deep_sleep_flag,
    .i_wake_req, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready(o_hreadyout), .o_hrdata,
    .o_hreadyout, .o_hresp, .o_gate_sys_clk, .o_gate_bus_clk, .o_keep_powered, .o_por_detect_off,
    .o_stop_mode, .o_in_stop);
  smcr_core_model u_core (.i_ref_clk, .o_sleep_req(i_sleep_req), .o_deep_sleep_flag(i_deep_sleep_flag),
    .o_wake_req(i_wake_req));
  always #10 i_ref_clk = ~i_ref_clk;
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      $display("[ERR] %0t bus timeout", $time);
      summarize();
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] wd, output logic [31:0] rd);
    i_hsel <= 1'b1;
    i_haddr <= a;
    i_htrans <= 2'b10;
    i_hwrite <= wr;
    wait_rdy();
    i_hsel <= 1'b0;
    i_htrans <= 2'b00;
    i_hwdata <= {24'h00_0000, wd};
    wait_rdy();
    rd = o_hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 8'h00, rd);
    chk(rd, exp);
    chk(32'(o_hresp), 32'h0000_0000);
  endtask
  task automatic t_reset_vals();
    rdc(A_PROT, 32'h0000_0000);
    rdc(A_PM, 32'h0000_0000);
    rdc(A_SC, 32'h0000_0000);
  endtask
  task automatic t_protect();
    wr(A_PM, 8'h03);
    rdc(A_PM, 32'h0000_0000);
    wr(A_PROT, 8'h28);
    rdc(A_PROT, 32'h0000_0028);
    wr(A_PM, 8'h03);
    rdc(A_PM, 32'h0000_0003);
    wr(A_PM, 8'h04);
    rdc(A_PM, 32'h0000_0003);
    wr(A_PROT, 8'h2A);
    rdc(A_PROT, 32'h0000_0028);
    wr(A_SC, 8'h41);
    i_sys_rst_n <= 1'b0;
    @(posedge i_ref_clk);
    i_sys_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    rdc(A_PM, 32'h0000_0003);
    rdc(A_SC, 32'h0000_0041);
    wr(A_PROT, 8'h2A);
    rdc(A_PM, 32'h0000_0000);
  endtask
  task automatic t_rsvd_bits();
    wr(A_SC, 8'hBB);
    rdc(A_SC, 32'h0000_00A3);
  endtask
  task automatic t_modes();
    // Selector, stop control, mode, then bus gate, keep powered, detect off
    logic [17:0] tab [9] = '{{3'h0, 8'h00, `SMCR_MODE_STOP, 3'b100}, {3'h0, 8'h40, `SMCR_MODE_PSTOP_GATED, 3'b110},
      {3'h0, 8'h80, `SMCR_MODE_PSTOP_RUN, 3'b010}, {3'h2, 8'h40, `SMCR_MODE_VLP_STOP, 3'b100},
      {3'h3, 8'h00, `SMCR_MODE_LEAK, 3'b100}, {3'h4, 8'h20, `SMCR_MODE_SUB0, 3'b101},
      {3'h4, 8'h00, `SMCR_MODE_SUB0, 3'b100}, {3'h4, 8'h21, `SMCR_MODE_SUB1, 3'b100},
      {3'h4, 8'h03, `SMCR_MODE_SUB3, 3'b100}};
    for (int i = 0; i < 9; i++) begin
      wr(A_SC, tab[i][14:7]);
      wr(A_PM, {5'b00000, tab[i][17:15]});
      u_core.sleep_now(1'b1, 1'b0);
      #1;
      chk(32'({o_in_stop, o_gate_sys_clk}), 32'h0000_0003);
      chk(32'(o_stop_mode), 32'(tab[i][6:3]));
      chk(32'({o_gate_bus_clk, o_keep_powered, o_por_detect_off}), 32'(tab[i][2:0]));
      @(posedge i_ref_clk);
      u_core.wake_up();
      #1;
      chk(32'(o_in_stop), 32'h0000_0000);
    end
  endtask
  task automatic t_abort();
    u_core.sleep_now(1'b0, 1'b0);
    #1;
    chk(32'(o_in_stop), 32'h0000_0000);
    @(posedge i_ref_clk);
    u_core.sleep_now(1'b1, 1'b1);
    #1;
    chk(32'(o_in_stop), 32'h0000_0000);
    rdc(A_PM, 32'h0000_000C);
    u_core.sleep_now(1'b1, 1'b0);
    @(posedge i_ref_clk);
    u_core.wake_up();
    rdc(A_PM, 32'h0000_0004);
  endtask
  initial begin
    i_ref_clk = 1'b0;
    i_arst_n = 1'b0;
    i_sys_rst_n = 1'b1;
    i_hsel = 1'b0;
    i_haddr = 32'h0000_0000;
    i_htrans = 2'b00;
    i_hwrite = 1'b0;
    i_hwdata = 32'h0000_0000;
    repeat (2) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    @(posedge i_ref_clk);
    t_reset_vals();
    t_protect();
    t_rsvd_bits();
    t_modes();
    t_abort();
    summarize();
  end
endmodule // tb
`default_nettype wire
